// ---- rtl/fcs_cmd_decode.sv ----
// Command code decoder for the nonvolatile-memory command logic.
// Assumes the code is a stable 8-bit register value.
module fcs_cmd_decode
  import fcs_pkg::*;
(
  input  wire logic [7:0] code,
  output logic            legal,
  output logic            modifies,
  output logic            is_blank,
  output logic            is_burst,
  output logic            is_mass,
  output logic            is_abort
);
  // Six accepted codes, the rest are illegal
  assign is_blank = (code == FCS_CMD_BLANK);
  assign is_burst = (code == FCS_CMD_BURST);
  assign is_mass  = (code == FCS_CMD_MASS);
  assign is_abort = (code == FCS_CMD_ABORT);
  assign modifies = (code == FCS_CMD_BYTE) || is_burst ||
                    (code == FCS_CMD_SECT) || is_mass;
  assign legal    = is_blank || modifies || is_abort;
endmodule

// ---- rtl/fcs_pkg.sv ----
// Constants shared by the nonvolatile-memory command and status logic.
// Assumes a 32-bit APB bus on pclk and one register of at most 8 bits per aligned word.
package fcs_pkg;
  // Register byte offsets
  localparam logic [7:0] FCS_OFF_STATUS  = 8'h00;
  localparam logic [7:0] FCS_OFF_COMMAND = 8'h04;
  localparam logic [7:0] FCS_OFF_DIVIDER = 8'h08;
  localparam logic [7:0] FCS_OFF_PROTECT = 8'h0c;
  localparam logic [7:0] FCS_OFF_SECURE  = 8'h10;
  // Status field positions
  localparam int FCS_BIT_CBE   = 7;
  localparam int FCS_BIT_CC    = 6;
  localparam int FCS_BIT_PV    = 5;
  localparam int FCS_BIT_AE    = 4;
  localparam int FCS_BIT_BLANK = 2;
  // Reset values and the open security setting
  localparam logic [7:0] FCS_RST_COMMAND = 8'h00;
  localparam logic [7:0] FCS_RST_DIVIDER = 8'h00;
  localparam logic [7:0] FCS_RST_PROTECT = 8'hff;
  localparam logic [1:0] FCS_RST_SECURE  = 2'h3;
  localparam logic [1:0] FCS_SEC_OPEN    = 2'h2;
  // Command codes
  localparam logic [7:0] FCS_CMD_BLANK  = 8'h05;
  localparam logic [7:0] FCS_CMD_BYTE   = 8'h20;
  localparam logic [7:0] FCS_CMD_BURST  = 8'h25;
  localparam logic [7:0] FCS_CMD_SECT   = 8'h40;
  localparam logic [7:0] FCS_CMD_MASS   = 8'h41;
  localparam logic [7:0] FCS_CMD_ABORT  = 8'h47;
  // Array-side sequencer states
  typedef enum logic [1:0] {FCS_IDLE, FCS_RUN} fcs_state_e;
endpackage

// ---- rtl/fcs_sector_guard.sv ----
// Protection check: is an address inside the protected top region.
// Assumes protect field of all ones means nothing is protected.
module fcs_sector_guard #(
  parameter int AW = 16,
  parameter int PW = 8
) (
  input  wire logic [AW-1:0] addr,
  input  wire logic [PW-1:0] prot,
  output logic               hit,
  output logic               any
);
  // Protected region begins at a boundary set by the field value
  logic [AW-1:0] bound;
  assign bound = {prot, {(AW-PW){1'b1}}};
  assign any   = (prot != {PW{1'b1}});
  assign hit   = any && (addr > bound);
endmodule

// ---- rtl/flash_command_status.sv ----
// Command launch and status flags of the nonvolatile-memory controller.
// Assumes an APB master on pclk and an array engine answering arr_done.
//
// The address map and the APB register port are this design's own decisions.
module flash_command_status
  import fcs_pkg::*;
#(
  parameter int AW = 16
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          arr_wr,
  input  wire logic [AW-1:0] arr_addr,
  input  wire logic          stop_req,
  input  wire logic          arr_done,
  input  wire logic          arr_erased,
  output logic               arr_start,
  output logic      [7:0]    arr_cmd,
  output logic      [AW-1:0] arr_cmd_addr,
  output logic               arr_busy
);
  import fcs_pkg::*;

  fcs_state_e      state_q, state_d;
  logic            cbe_q, cc_q, pv_q, ae_q, blank_q;
  logic [7:0]      cmd_q, div_q, prot_q;
  logic            div_set_q, addr_seen_q, blank_run_q;
  logic [1:0]      sec_q;
  logic [AW-1:0]   addr_q;
  logic            pend_q;
  logic [7:0]      pend_cmd_q;
  logic [AW-1:0]   pend_addr_q;
  logic            start_q;
  logic [31:0]     rdata_q;
  logic            ready_q, err_q;
  logic            busy_q;

  // Bus decode
  logic setup, wr, rd, hit_st, hit_cmd, hit_div, hit_prot, hit_sec, mapped;
  assign setup    = psel && !penable;
  // Writes commit at the access edge on which pready is seen high
  assign wr       = psel && penable && pwrite && ready_q;
  assign rd       = setup && !pwrite;
  assign hit_st   = (paddr == FCS_OFF_STATUS);
  assign hit_cmd  = (paddr == FCS_OFF_COMMAND);
  assign hit_div  = (paddr == FCS_OFF_DIVIDER);
  assign hit_prot = (paddr == FCS_OFF_PROTECT);
  assign hit_sec  = (paddr == FCS_OFF_SECURE);
  assign mapped   = hit_st || hit_cmd || hit_div || hit_prot || hit_sec;

  // Command decode and protection check
  logic legal, modifies, is_blank, is_burst, is_mass, is_abort, prot_hit, prot_any;
  fcs_cmd_decode u_dec (
    .code     (cmd_q),
    .legal    (legal),
    .modifies (modifies),
    .is_blank (is_blank),
    .is_burst (is_burst),
    .is_mass  (is_mass),
    .is_abort (is_abort)
  );
  fcs_sector_guard #(.AW(AW), .PW(8)) u_guard (
    .addr (addr_q),
    .prot (prot_q),
    .hit  (prot_hit),
    .any  (prot_any)
  );

  // Launch qualification
  logic launch_wr, launch, seq_err, div_err, pv_err, busy, handoff, stop_err;
  assign busy      = (state_q == FCS_RUN);
  assign launch_wr = wr && hit_st && pwdata[FCS_BIT_CBE];
  assign seq_err   = launch_wr && (!cbe_q || !addr_seen_q ||
                     (pend_q && !is_burst) || !legal ||
                     (busy && !is_burst && !is_abort));
  assign div_err   = launch_wr && modifies && !div_set_q;
  assign pv_err    = launch_wr && !seq_err && !div_err &&
                     ((modifies && !is_mass && prot_hit) ||
                      (is_mass && prot_any));
  assign launch    = launch_wr && !seq_err && !div_err && !pv_err;
  assign handoff   = pend_q && (!busy || arr_done);
  assign stop_err  = stop_req && busy;

  // Array engine state: burst commands queue one deep behind the running one
  always_comb begin
    state_d = state_q;
    case (state_q)
      FCS_IDLE: if (handoff) state_d = FCS_RUN;
      FCS_RUN:  if ((arr_done && !pend_q) || stop_err) state_d = FCS_IDLE;
      default:  state_d = FCS_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= FCS_IDLE;
      busy_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_q  <= (state_d == FCS_RUN);
    end
  end

  // Command, address latch and buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q       <= FCS_RST_COMMAND;
      addr_q      <= '0;
      addr_seen_q <= 1'b0;
      pend_q      <= 1'b0;
      pend_cmd_q  <= FCS_RST_COMMAND;
      pend_addr_q <= '0;
      start_q     <= 1'b0;
      arr_cmd     <= FCS_RST_COMMAND;
      arr_cmd_addr <= '0;
      blank_run_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (wr && hit_cmd && cbe_q) cmd_q <= pwdata[7:0];
      if (arr_wr && cbe_q) begin
        addr_q      <= arr_addr;
        addr_seen_q <= 1'b1;
      end
      // Any launch attempt uses up the latched address, refused or not
      if (launch_wr) addr_seen_q <= 1'b0;
      if (launch) begin
        pend_q      <= 1'b1;
        pend_cmd_q  <= cmd_q;
        pend_addr_q <= addr_q;
      end else if (handoff || stop_err) begin
        pend_q <= 1'b0;
      end
      if (handoff) begin
        start_q      <= 1'b1;
        arr_cmd      <= pend_cmd_q;
        arr_cmd_addr <= pend_addr_q;
        blank_run_q  <= (pend_cmd_q == FCS_CMD_BLANK);
      end
    end
  end

  // Status flags; hardware set wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cbe_q   <= 1'b1;
      cc_q    <= 1'b1;
      pv_q    <= 1'b0;
      ae_q    <= 1'b0;
      blank_q <= 1'b0;
    end else begin
      if (launch) begin
        cbe_q <= 1'b0;
      end else if (handoff && !launch) begin
        cbe_q <= 1'b1;
      end else if (!pend_q && !busy) begin
        cbe_q <= 1'b1;
      end
      if (launch) cc_q <= 1'b0;
      else if (!pend_q && !busy && !start_q) cc_q <= 1'b1;
      if (pv_err) pv_q <= 1'b1;
      else if (wr && hit_st && pwdata[FCS_BIT_PV]) pv_q <= 1'b0;
      if (seq_err || div_err || stop_err) ae_q <= 1'b1;
      else if (wr && hit_st && pwdata[FCS_BIT_AE]) ae_q <= 1'b0;
      if (launch) blank_q <= 1'b0;
      else if (busy && arr_done && blank_run_q && arr_erased) blank_q <= 1'b1;
    end
  end

  // Divider, protection and security registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q     <= FCS_RST_DIVIDER;
      div_set_q <= 1'b0;
      prot_q    <= FCS_RST_PROTECT;
      sec_q     <= FCS_RST_SECURE;
    end else begin
      if (wr && hit_div) begin
        div_q     <= pwdata[7:0];
        div_set_q <= 1'b1;
      end
      if (wr && hit_prot && (pwdata[7:0] <= prot_q)) prot_q <= pwdata[7:0];
      if (busy && arr_done && blank_run_q && arr_erased) sec_q <= FCS_SEC_OPEN;
    end
  end

  // Read mux; undefined status bits read zero
  logic [7:0] status_v;
  logic [31:0] rmux;
  assign status_v = {cbe_q, cc_q, pv_q, ae_q, 1'b0, blank_q, 2'b00};
  assign rmux = hit_st   ? {24'h000000, status_v} :
                hit_cmd  ? {24'h000000, cmd_q}    :
                hit_div  ? {24'h000000, div_q}    :
                hit_prot ? {24'h000000, prot_q}   :
                hit_sec  ? {30'h0, sec_q}         : 32'h00000000;

  // APB answer: no wait state, access phase ends the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h00000000;
      ready_q <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      ready_q <= setup;
      err_q   <= setup && !mapped;
      if (rd) rdata_q <= rmux;
    end
  end

  assign prdata    = rdata_q;
  assign pready    = ready_q;
  assign pslverr   = err_q;
  assign arr_start = start_q;
  assign arr_busy  = busy_q;
endmodule

// ---- tb/fcs_array_model.sv ----
// Behavioural memory array: finishes each handoff after a delay unless stop_req drops it.
// Assumes arr_start pulses from the command block on pclk.
module fcs_array_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic arr_start,
  input  wire logic stop_req,
  input  wire logic slow,
  input  wire logic erased,
  output logic      arr_done,
  output logic      arr_erased
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Countdown from handoff; stop drops it; result inverted off done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      arr_done <= 1'b0;
      arr_erased <= 1'b0;
    end else begin
      arr_done <= cnt == 1 && !stop_req;
      arr_erased <= (cnt == 1) ? erased : !erased;
      if (arr_start) cnt <= slow ? 40 : 3;
      else if (stop_req) cnt <= 0;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
endmodule

// ---- tb/fcs_monitor.sv ----
// Port checker for the command and status block, bound below.
// Assumes one pclk domain with presetn as its reset.
module fcs_monitor #(
  parameter int AW = 16
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          stop_req,
  input wire logic          arr_done,
  input wire logic          arr_start,
  input wire logic [7:0]    arr_cmd,
  input wire logic [AW-1:0] arr_cmd_addr,
  input wire logic          arr_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Register map decode
  wire mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  sequence s_setup; psel && !penable; endsequence
  sequence s_stat_rd; s_setup ##0 !pwrite && paddr == 8'h00; endsequence
  a_pready_answer: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  a_slverr_map: assert property (s_setup |=> pslverr == !$past(mapped))
    else $error("pslverr wrong for address");
  a_status_zero: assert property (s_stat_rd ##1 pready |-> prdata[31:8] == 24'h0 &&
    prdata[3] == 1'b0 && prdata[1:0] == 2'h0) else $error("undefined status bits set");
  a_cc_busy: assert property (s_stat_rd ##0 arr_busy ##1 pready |-> !prdata[6])
    else $error("complete flag set while busy");
  a_start_code: assert property (arr_start |-> arr_cmd inside {8'h05, 8'h20,
    8'h25, 8'h40, 8'h41, 8'h47}) else $error("unknown code handed to array");
  a_start_pulse: assert property (arr_start |=> !arr_start)
    else $error("handoff longer than one cycle");
  a_cmd_hold: assert property (arr_start |=> ($stable(arr_cmd) && $stable(arr_cmd_addr))[*3])
    else $error("command changed after handoff");
  a_done_idle: assert property (arr_busy && arr_done |=> !arr_busy || arr_start)
    else $error("busy kept after done");
  a_stop_abort: assert property (arr_busy && stop_req |-> ##[1:2] !arr_busy)
    else $error("stop did not abort");
endmodule

bind flash_command_status fcs_monitor #(.AW(AW)) i_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .stop_req(stop_req), .arr_done(arr_done),
  .arr_start(arr_start), .arr_cmd(arr_cmd), .arr_cmd_addr(arr_cmd_addr), .arr_busy(arr_busy));

// ---- tb/flash_command_status_tb.sv ----
// Self-checking bench for the command and status block.
// Assumes the array model and the bound port checker.
module flash_command_status_tb
  import fcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0]  paddr = 0, arr_cmd, last_cmd;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, arr_wr = 0, stop_req = 0, arr_done, arr_erased;
  logic [15:0] arr_addr = 0, arr_cmd_addr;
  logic        arr_start, arr_busy, slow = 0, erased = 0;
  int          bad_count = 0, comparisons = 0, starts = 0;
  always #2.5 pclk = ~pclk;
  flash_command_status #(.AW(16)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .arr_wr(arr_wr), .arr_addr(arr_addr),
    .stop_req(stop_req), .arr_done(arr_done), .arr_erased(arr_erased),
    .arr_start(arr_start), .arr_cmd(arr_cmd), .arr_cmd_addr(arr_cmd_addr),
    .arr_busy(arr_busy));
  fcs_array_model i_arr (.pclk(pclk), .presetn(presetn), .arr_start(arr_start),
    .stop_req(stop_req), .slow(slow), .erased(erased), .arr_done(arr_done),
    .arr_erased(arr_erased));
  // Handoff tally
  always @(posedge pclk) if (arr_start === 1'b1) begin
    starts++;
    last_cmd = arr_cmd;
  end
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin bad_count++; summarize(); end
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic stat;
    apb(0, FCS_OFF_STATUS, 32'h0);
  endtask
  // Address latch, code, then launch
  task automatic issue(input logic [7:0] c, input logic [15:0] a, input logic wr);
    @(posedge pclk);
    arr_wr <= wr; arr_addr <= a;
    @(posedge pclk);
    arr_wr <= 0;
    apb(1, FCS_OFF_COMMAND, {24'h0, c});
    apb(1, FCS_OFF_STATUS, 32'h80);
  endtask
  task automatic wait_cc;
    int n = 0;
    do begin stat(); n++; end while (rd[6] !== 1'b1 && n < 40);
    if (n >= 40) begin bad_count++; summarize(); end
  endtask
  task automatic launch(input logic [7:0] c, input logic [15:0] a, input logic wr);
    issue(c, a, wr);
    wait_cc();
  endtask
  task automatic t_reset;
    stat();
    chk("status", 32'hc0, rd);
    apb(0, FCS_OFF_PROTECT, 32'h0);
    chk("protect", {24'h0, FCS_RST_PROTECT}, rd);
    apb(0, FCS_OFF_SECURE, 32'h0);
    chk("secure_rst", {30'h0, FCS_RST_SECURE}, rd);
    apb(0, 8'h14, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
  endtask
  task automatic t_errors;
    launch(FCS_CMD_BYTE, 16'h1000, 1);
    chk("nodiv", 32'hd0, rd);
    apb(1, FCS_OFF_STATUS, 32'h4f);
    stat();
    chk("wr0", 32'hd0, rd);
    apb(1, FCS_OFF_STATUS, 32'h10);
    stat();
    chk("wr1", 32'hc0, rd);
    apb(1, FCS_OFF_DIVIDER, 32'h1);
    launch(8'h11, 16'h1000, 1);
    chk("illegal", 32'hd0, rd);
    apb(1, FCS_OFF_STATUS, 32'h10);
    launch(FCS_CMD_BYTE, 16'h1000, 0);
    chk("noaddr", 32'hd0, rd);
    apb(1, FCS_OFF_STATUS, 32'h10);
    chk("starts", 32'h0, starts);
  endtask
  task automatic t_codes;
    logic [7:0] codes[6] = '{FCS_CMD_BLANK, FCS_CMD_BYTE, FCS_CMD_BURST, FCS_CMD_SECT,
      FCS_CMD_MASS, FCS_CMD_ABORT};
    foreach (codes[i]) begin
      launch(codes[i], 16'h2000, 1);
      chk("code", {24'h0, codes[i]}, {24'h0, last_cmd});
      chk("done", 32'hc0, rd);
    end
    chk("count", 32'h6, starts);
  endtask
  task automatic t_blank;
    erased <= 1;
    launch(FCS_CMD_BLANK, 16'h0, 1);
    chk("blank", 32'hc4, rd);
    apb(0, FCS_OFF_SECURE, 32'h0);
    chk("secure", {30'h0, FCS_SEC_OPEN}, rd);
    apb(1, FCS_OFF_STATUS, 32'h0);
    stat();
    chk("blankwr", 32'hc4, rd);
    erased <= 0;
    launch(FCS_CMD_BYTE, 16'h0, 1);
    chk("blankclr", 32'hc0, rd);
  endtask
  task automatic t_prot;
    apb(1, FCS_OFF_PROTECT, 32'hfe);
    launch(FCS_CMD_BYTE, 16'hff00, 1);
    chk("prot", 32'he0, rd);
    apb(1, FCS_OFF_STATUS, 32'h0);
    stat();
    chk("pv0", 32'he0, rd);
    apb(1, FCS_OFF_STATUS, 32'h20);
    stat();
    chk("pv1", 32'hc0, rd);
    launch(FCS_CMD_MASS, 16'h0, 1);
    chk("mass", 32'he0, rd);
    apb(1, FCS_OFF_STATUS, 32'h20);
    chk("starts", 32'h8, starts);
  endtask
  task automatic t_stop;
    slow <= 1;
    issue(FCS_CMD_BURST, 16'h1000, 1);
    stat();
    chk("burst", 32'h80, rd);
    issue(FCS_CMD_BURST, 16'h1002, 1);
    stat();
    chk("full", 32'h0, rd);
    wait_cc();
    chk("burstdone", 32'hc0, rd);
    chk("bursts", 32'ha, starts);
    issue(FCS_CMD_SECT, 16'h1000, 1);
    stop_req <= 1;
    wait_cc();
    stop_req <= 0;
    chk("stop", 32'hd0, rd);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    t_reset();
    t_errors();
    t_codes();
    t_blank();
    t_prot();
    t_stop();
    summarize();
  end
endmodule
